//--- logic/cmcfg_pkg.sv
//======================================================================
// What this block does
// - silence, three escape chars, silence enters
// - guard-before default is 500 ms
// - guard-before is 16 bits of ms
// - escape char 0x20..0x7f, default plus sign
// - exit command returns to data mode
// - command timeout in 100 ms, default 0xc8
// - rx indicator pin: activity, high, low
// - flow pin: cts, rs485 low/high, high, low
// - cts tells host when to send
// - xon/xoff pause transfer when enabled and flow pin is cts
// - 16-bit destination; mismatched data not forwarded
// - channel range 0..6 hopping, 0..0x18 single
// - single channel code selects 300 kHz step
// - idle count expiry forces long initializer
// - initializer holdoff is 16 bits
// - force command prefixes next transmission
// - signal strength byte clamps 0x25..0x6a
package cmcfg_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned TICK_MS_CYC = MS_NS / CLK_NS;
   localparam int unsigned TENTH_MS = 100;
   localparam logic [15:0] GUARD_BEFORE_RST = 16'h01f4;
   localparam logic [15:0] GUARD_AFTER_RST = 16'h01f4;
   localparam logic [7:0] ESC_RST = 8'h2b;
   localparam logic [7:0] ESC_MIN = 8'h20;
   localparam logic [7:0] ESC_MAX = 8'h7f;
   localparam logic [15:0] CMD_TMO_RST = 16'h00c8;
   localparam logic [15:0] CMD_TMO_MIN = 16'h0002;
   localparam logic [7:0] XON_CHAR = 8'h11;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [4:0] CHAN_HOP_MAX = 5'h06;
   localparam logic [4:0] CHAN_SGL_MAX = 5'h18;
   localparam logic [13:0] FREQ_BASE_100K = 14'h2391;
   localparam logic [13:0] FREQ_STEP_100K = 14'h0003;
   localparam logic [7:0] RSSI_MIN = 8'h25;
   localparam logic [7:0] RSSI_MAX = 8'h6a;
   localparam logic [1:0] ESC_COUNT = 2'h3;
   typedef enum logic [1:0] {CMCFG_RXI_ACT, CMCFG_RXI_HIGH,
      CMCFG_RXI_LOW} cmcfg_rxi_t;
   typedef enum logic [2:0] {CMCFG_FL_CTS, CMCFG_FL_485L, CMCFG_FL_HIGH,
      CMCFG_FL_485H, CMCFG_FL_LOW} cmcfg_flow_t;
endpackage : cmcfg_pkg

//--- logic/cmcfg_top.sv
`timescale 1ns/1ps
module cmcfg_top #(
   parameter int unsigned TICK_MS_CYC = cmcfg_pkg::TICK_MS_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // serial receive byte stream
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   // commands decoded while in command mode
   input wire logic i_exit_command,
   input wire logic i_force_initializer,
   // configuration writes
   input wire logic i_cfg_we,
   input wire logic [15:0] i_guard_before_time,
   input wire logic [15:0] i_guard_after_time,
   input wire logic [7:0] i_escape_char_setting,
   input wire logic [15:0] i_command_timeout,
   input wire logic [1:0] i_rx_indicator_config,
   input wire logic [2:0] i_flow_config,
   input wire logic i_soft_flow_enable,
   input wire logic [15:0] i_dest_address,
   input wire logic i_single_freq_mode,
   input wire logic [4:0] i_channel_select,
   input wire logic [15:0] i_initializer_holdoff,
   // modem side status
   input wire logic i_rx_activity,
   input wire logic i_tx_active,
   input wire logic i_host_room,
   input wire logic i_rf_pkt_valid,
   input wire logic [15:0] i_rf_pkt_addr,
   input wire logic [4:0] i_rf_pkt_chan,
   input wire logic [7:0] i_rf_pkt_rssi,
   input wire logic i_rf_init_seen,
   input wire logic i_tx_start,
   // outputs
   output logic o_command_mode,
   output logic o_rx_data_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_indicator_pin,
   output logic o_flow_output_pin,
   output logic o_rf_forward,
   output logic [13:0] o_freq_100khz,
   output logic o_send_initializer,
   output logic [7:0] o_signal_strength_query,
   output logic [15:0] o_dest_address,
   output logic [4:0] o_channel_select
);
   //===================================================================
   // configuration
   logic [15:0] gb_q, ga_q, ct_q, ht_q, dst_q;
   logic [7:0] esc_q;
   logic [1:0] rxi_q;
   logic [2:0] flc_q;
   logic sfl_q, sgl_q;
   logic [4:0] ch_q;
   wire esc_ok = i_escape_char_setting >= cmcfg_pkg::ESC_MIN &&
      i_escape_char_setting <= cmcfg_pkg::ESC_MAX;
   wire ct_ok = i_command_timeout >= cmcfg_pkg::CMD_TMO_MIN;
   wire [4:0] ch_max = i_single_freq_mode ? cmcfg_pkg::CHAN_SGL_MAX :
      cmcfg_pkg::CHAN_HOP_MAX;
   wire ch_ok = i_channel_select <= ch_max;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         gb_q <= cmcfg_pkg::GUARD_BEFORE_RST;
         ga_q <= cmcfg_pkg::GUARD_AFTER_RST;
         esc_q <= cmcfg_pkg::ESC_RST;
         ct_q <= cmcfg_pkg::CMD_TMO_RST;
         rxi_q <= 2'h0;
         flc_q <= 3'h0;
         sfl_q <= 1'b0;
         dst_q <= 16'h0000;
         sgl_q <= 1'b0;
         ch_q <= 5'h00;
         ht_q <= 16'hffff;
      end else if (i_cfg_we) begin
         gb_q <= i_guard_before_time;
         ga_q <= i_guard_after_time;
         if (esc_ok) begin
            esc_q <= i_escape_char_setting;
         end
         if (ct_ok) begin
            ct_q <= i_command_timeout;
         end
         if (i_rx_indicator_config <= cmcfg_pkg::CMCFG_RXI_LOW) begin
            rxi_q <= i_rx_indicator_config;
         end
         if (i_flow_config <= cmcfg_pkg::CMCFG_FL_LOW) begin
            flc_q <= i_flow_config;
         end
         sfl_q <= i_soft_flow_enable;
         dst_q <= i_dest_address;
         sgl_q <= i_single_freq_mode;
         if (ch_ok) begin
            ch_q <= i_channel_select;
         end
         ht_q <= i_initializer_holdoff;
      end
   end
   //===================================================================
   // millisecond and 100 ms ticks
   logic [31:0] tick_cnt_q;
   logic [6:0] tenth_cnt_q;
   wire ms_tick = tick_cnt_q == TICK_MS_CYC - 1;
   wire tenth_tick = ms_tick &&
      tenth_cnt_q == 7'(cmcfg_pkg::TENTH_MS - 1);
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tick_cnt_q <= 32'h0;
         tenth_cnt_q <= 7'h0;
      end else begin
         tick_cnt_q <= ms_tick ? 32'h0 : tick_cnt_q + 32'h1;
         if (ms_tick) begin
            tenth_cnt_q <= tenth_tick ? 7'h0 : tenth_cnt_q + 7'h1;
         end
      end
   end
   //===================================================================
   // escape sequence recogniser
   typedef enum logic [2:0] {CMCFG_S_DATA, CMCFG_S_ARMED, CMCFG_S_ESC,
      CMCFG_S_AFTER, CMCFG_S_CMD} cmcfg_state_t;
   cmcfg_state_t st_q, st_d;
   logic [15:0] quiet_ms_q, cmd_idle_q;
   logic [1:0] esc_cnt_q;
   wire is_esc = i_rx_data == esc_q;
   wire gb_met = quiet_ms_q >= gb_q;
   wire ga_met = quiet_ms_q >= ga_q;
   wire ct_exp = cmd_idle_q >= ct_q;
   logic pass_byte;
   always_comb begin
      st_d = st_q;
      pass_byte = 1'b0;
      case (st_q)
         CMCFG_S_DATA, CMCFG_S_ARMED: begin
            if (i_rx_valid && is_esc && (st_q == CMCFG_S_ARMED || gb_met))
            begin
               st_d = CMCFG_S_ESC;
            end else if (i_rx_valid) begin
               st_d = CMCFG_S_DATA;
               pass_byte = 1'b1;
            end else if (gb_met) begin
               st_d = CMCFG_S_ARMED;
            end
         end
         CMCFG_S_ESC: begin
            if (i_rx_valid && !is_esc) begin
               st_d = CMCFG_S_DATA;
               pass_byte = 1'b1;
            end else if (i_rx_valid && esc_cnt_q == cmcfg_pkg::ESC_COUNT - 1)
            begin
               st_d = CMCFG_S_AFTER;
            end
         end
         CMCFG_S_AFTER: begin
            if (i_rx_valid) begin
               st_d = CMCFG_S_DATA;
               pass_byte = 1'b1;
            end else if (ga_met) begin
               st_d = CMCFG_S_CMD;
            end
         end
         CMCFG_S_CMD: begin
            if (i_exit_command) begin
               st_d = CMCFG_S_DATA;
            end else if (ct_exp && !i_rx_valid) begin
               st_d = CMCFG_S_DATA;
            end
         end
         default: st_d = CMCFG_S_DATA;
      endcase
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_q <= CMCFG_S_DATA;
         quiet_ms_q <= 16'h0;
         cmd_idle_q <= 16'h0;
         esc_cnt_q <= 2'h0;
      end else begin
         st_q <= st_d;
         if (i_rx_valid) begin
            quiet_ms_q <= 16'h0;
         end else if (ms_tick && quiet_ms_q != 16'hffff) begin
            quiet_ms_q <= quiet_ms_q + 16'h1;
         end
         if (i_rx_valid || st_q != CMCFG_S_CMD) begin
            cmd_idle_q <= 16'h0;
         end else if (tenth_tick && cmd_idle_q != 16'hffff) begin
            cmd_idle_q <= cmd_idle_q + 16'h1;
         end
         if (st_d != CMCFG_S_ESC) begin
            esc_cnt_q <= 2'h0;
         end else if (i_rx_valid) begin
            esc_cnt_q <= esc_cnt_q + 2'h1;
         end
      end
   end
   //===================================================================
   // flow control and pins
   logic xoff_q;
   wire cts_ok = i_host_room && !(sfl_q && xoff_q);
   logic flow_d, rxi_d;
   always_comb begin
      case (flc_q)
         cmcfg_pkg::CMCFG_FL_CTS: flow_d = !cts_ok;
         cmcfg_pkg::CMCFG_FL_485L: flow_d = !i_tx_active;
         cmcfg_pkg::CMCFG_FL_HIGH: flow_d = 1'b1;
         cmcfg_pkg::CMCFG_FL_485H: flow_d = i_tx_active;
         default: flow_d = 1'b0;
      endcase
      case (rxi_q)
         cmcfg_pkg::CMCFG_RXI_ACT: rxi_d = i_rx_activity;
         cmcfg_pkg::CMCFG_RXI_HIGH: rxi_d = 1'b1;
         default: rxi_d = 1'b0;
      endcase
   end
   //===================================================================
   // rf side: forwarding, initializer, strength
   logic [15:0] idle_tenth_q;
   logic force_q, synced_q;
   wire traffic = i_rx_valid || i_tx_start || i_rf_pkt_valid;
   // all ones holdoff means the idle count never requests the long initializer (a forced one is still sent)
   wire hold_exp = idle_tenth_q >= ht_q && ht_q != 16'hffff;
   wire [7:0] rssi_c = i_rf_pkt_rssi < cmcfg_pkg::RSSI_MIN ?
      cmcfg_pkg::RSSI_MIN : i_rf_pkt_rssi > cmcfg_pkg::RSSI_MAX ?
      cmcfg_pkg::RSSI_MAX : i_rf_pkt_rssi;
   wire fwd = i_rf_pkt_valid && synced_q && i_rf_pkt_addr == dst_q &&
      i_rf_pkt_chan == ch_q;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         xoff_q <= 1'b0;
         idle_tenth_q <= 16'h0;
         force_q <= 1'b0;
         synced_q <= 1'b0;
         o_command_mode <= 1'b0;
         o_rx_data_valid <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_indicator_pin <= 1'b0;
         o_flow_output_pin <= 1'b1;
         o_rf_forward <= 1'b0;
         o_freq_100khz <= cmcfg_pkg::FREQ_BASE_100K;
         o_send_initializer <= 1'b0;
         o_signal_strength_query <= cmcfg_pkg::RSSI_MIN;
         o_dest_address <= 16'h0;
         o_channel_select <= 5'h0;
      end else begin
         if (pass_byte && sfl_q && i_rx_data == cmcfg_pkg::XOFF_CHAR) begin
            xoff_q <= 1'b1;
         end else if (pass_byte && sfl_q &&
            i_rx_data == cmcfg_pkg::XON_CHAR) begin
            xoff_q <= 1'b0;
         end
         if (traffic) begin
            idle_tenth_q <= 16'h0;
         end else if (tenth_tick && idle_tenth_q != 16'hffff) begin
            idle_tenth_q <= idle_tenth_q + 16'h1;
         end
         if (i_force_initializer && st_q == CMCFG_S_CMD) begin
            force_q <= 1'b1;
         end else if (i_tx_start) begin
            force_q <= 1'b0;
         end
         if (i_rf_init_seen) begin
            synced_q <= 1'b1;
         end
         o_command_mode <= st_d == CMCFG_S_CMD;
         o_rx_data_valid <= pass_byte;
         o_rx_data <= i_rx_data;
         o_rx_indicator_pin <= rxi_d;
         o_flow_output_pin <= flow_d;
         o_rf_forward <= fwd;
         o_freq_100khz <= cmcfg_pkg::FREQ_BASE_100K +
            14'(ch_q) * cmcfg_pkg::FREQ_STEP_100K;
         if (i_tx_start) begin
            o_send_initializer <= force_q || hold_exp;
         end
         if (i_rf_pkt_valid) begin
            o_signal_strength_query <= rssi_c;
         end
         o_dest_address <= dst_q;
         o_channel_select <= ch_q;
      end
   end
   //===================================================================
   // checks
   exit_cmd_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      st_q == CMCFG_S_CMD && i_exit_command |=> !o_command_mode)
      else $error("exit command did not leave command mode");
   enter_seq_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(o_command_mode) |-> $past(st_q) == CMCFG_S_AFTER)
      else $error("command mode entered without escape sequence");
   stray_abort_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      st_q == CMCFG_S_AFTER && i_rx_valid |=> st_q == CMCFG_S_DATA)
      else $error("stray character did not abort entry");
   cts_xoff_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      flc_q == 3'h0 && sfl_q && xoff_q |=> o_flow_output_pin)
      else $error("xoff did not stop host");
   rxi_fix_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      rxi_q == 2'h2 |=> !o_rx_indicator_pin)
      else $error("rx indicator not held low");
   flow_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      flc_q == 3'h4 |=> !o_flow_output_pin)
      else $error("flow pin not held low");
   fwd_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_rf_forward |-> $past(i_rf_pkt_addr) == $past(dst_q))
      else $error("packet forwarded with wrong address");
   rssi_rng_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_signal_strength_query >= cmcfg_pkg::RSSI_MIN &&
      o_signal_strength_query <= cmcfg_pkg::RSSI_MAX)
      else $error("signal strength out of range");
   force_init_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      force_q && i_tx_start |=> o_send_initializer)
      else $error("forced initializer not sent");
   enter_c: cover property (@(posedge i_clk_sys) $rose(o_command_mode));
   tmo_c: cover property (@(posedge i_clk_sys)
      st_q == CMCFG_S_CMD && ct_exp ##1 !o_command_mode);
   init_c: cover property (@(posedge i_clk_sys) o_send_initializer);
   tmo_exit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      st_q == CMCFG_S_CMD && ct_exp && !i_rx_valid |=> !o_command_mode)
      else $error("command timeout did not leave command mode");
   sync_fwd_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_rf_forward |-> $past(synced_q))
      else $error("packet forwarded before sync");
   flow_high_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      flc_q == cmcfg_pkg::CMCFG_FL_HIGH |=> o_flow_output_pin)
      else $error("flow pin not held high");
   init_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_tx_start && hold_exp |=> o_send_initializer)
      else $error("expired holdoff did not request initializer");
   rssi_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !$past(i_rf_pkt_valid) |-> $stable(o_signal_strength_query))
      else $error("signal strength changed without a packet");
   //===================================================================
   // further cover points
   abort_c: cover property (@(posedge i_clk_sys)
      st_q == CMCFG_S_ESC && i_rx_valid && !is_esc);
   fwd_c: cover property (@(posedge i_clk_sys) o_rf_forward);
endmodule : cmcfg_top

//--- sim/cmcfg_host_model.sv
`timescale 1ns/1ps
module cmcfg_host_model (
   // clock
   input wire logic i_clk_sys,
   // device flow pin, low lets the host send
   input wire logic i_flow_output_pin,
   // byte strobe toward the device
   output logic o_rx_valid,
   output logic [7:0] o_rx_data
);
   //==========================================
   // byte sender
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h5a;
   end
   task automatic send(input logic [7:0] b, output bit ok);
      int n;
      n = 0;
      while (i_flow_output_pin !== 1'b0 && n < 1000) begin
         @(posedge i_clk_sys);
         n++;
      end
      ok = (n < 1000);
      @(posedge i_clk_sys);
      #1;
      o_rx_valid = 1'b1;
      o_rx_data = b;
      @(posedge i_clk_sys);
      #1;
      o_rx_valid = 1'b0;
      // released line shows the inverse
      o_rx_data = ~b;
   endtask : send
endmodule : cmcfg_host_model

//--- sim/test_cmcfg_top.sv
`timescale 1ns/1ps
module test_cmcfg_top;
   //==========================================
   // signals
   logic i_clk_sys, i_rst, i_rx_valid, i_exit_command, i_force_initializer;
   logic i_cfg_we, i_soft_flow_enable, i_single_freq_mode, i_rx_activity;
   logic i_tx_active, i_host_room, i_rf_pkt_valid, i_rf_init_seen;
   logic i_tx_start, o_command_mode, o_rx_data_valid, o_rx_indicator_pin;
   logic o_flow_output_pin, o_rf_forward, o_send_initializer;
   logic [7:0] i_rx_data, i_escape_char_setting, i_rf_pkt_rssi, last_rx;
   logic [7:0] o_rx_data, o_signal_strength_query;
   logic [15:0] i_guard_before_time, i_guard_after_time, i_command_timeout;
   logic [15:0] i_dest_address, i_initializer_holdoff, i_rf_pkt_addr;
   logic [15:0] o_dest_address;
   logic [1:0] i_rx_indicator_config;
   logic [2:0] i_flow_config;
   logic [4:0] i_channel_select, i_rf_pkt_chan, o_channel_select;
   logic [13:0] o_freq_100khz;
   int errors, samples_checked, nrx, wcnt;

   cmcfg_top #(.TICK_MS_CYC(10)) i_dut (.i_clk_sys, .i_rst, .i_rx_valid,
      .i_rx_data, .i_exit_command, .i_force_initializer, .i_cfg_we,
      .i_guard_before_time, .i_guard_after_time, .i_escape_char_setting,
      .i_command_timeout, .i_rx_indicator_config, .i_flow_config,
      .i_soft_flow_enable, .i_dest_address, .i_single_freq_mode,
      .i_channel_select, .i_initializer_holdoff, .i_rx_activity,
      .i_tx_active, .i_host_room, .i_rf_pkt_valid, .i_rf_pkt_addr,
      .i_rf_pkt_chan, .i_rf_pkt_rssi, .i_rf_init_seen, .i_tx_start,
      .o_command_mode, .o_rx_data_valid, .o_rx_data, .o_rx_indicator_pin,
      .o_flow_output_pin, .o_rf_forward, .o_freq_100khz,
      .o_send_initializer, .o_signal_strength_query, .o_dest_address,
      .o_channel_select);
   cmcfg_host_model i_host (.i_clk_sys, .i_flow_output_pin(o_flow_output_pin),
      .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      if (o_rx_data_valid === 1'b1) begin
         last_rx <= o_rx_data;
         nrx <= nrx + 1;
      end
   end
   //==========================================
   // helpers
   task automatic finish_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick
   task automatic put(input logic [7:0] b);
      bit ok;
      i_host.send(b, ok);
      if (!ok) begin
         errors++;
         finish_test();
      end
   endtask : put
   task automatic wait_mode(input logic v, input int lim);
      wcnt = 0;
      while (o_command_mode !== v) begin
         tick(1);
         wcnt++;
         if (wcnt > lim) begin
            errors++;
            finish_test();
         end
      end
   endtask : wait_mode
   task automatic cfg();
      i_cfg_we = 1'b1;
      tick(1);
      i_cfg_we = 1'b0;
      tick(1);
   endtask : cfg
   task automatic enter(input logic [7:0] e);
      tick(50);
      repeat (3) put(e);
      wait_mode(1'b1, 100);
      chk(o_command_mode, 1'b1);
   endtask : enter
   task automatic leave();
      i_exit_command = 1'b1;
      tick(1);
      i_exit_command = 1'b0;
      tick(1);
      chk(o_command_mode, 1'b0);
   endtask : leave
   task automatic pkt(input logic [15:0] a, input logic [4:0] c,
         input logic [7:0] r, input logic f);
      {i_rf_pkt_addr, i_rf_pkt_chan, i_rf_pkt_rssi} = {a, c, r};
      i_rf_pkt_valid = 1'b1;
      tick(1);
      i_rf_pkt_valid = 1'b0;
      chk(o_rf_forward, f);
      tick(1);
   endtask : pkt
   task automatic txs(input logic e);
      i_tx_start = 1'b1;
      tick(1);
      i_tx_start = 1'b0;
      chk(o_send_initializer, e);
      tick(1);
   endtask : txs
   //==========================================
   // scenarios
   task automatic t_defaults();
      tick(5100);
      repeat (3) put(8'h2b);
      tick(4800);
      chk(o_command_mode, 1'b0);
      wait_mode(1'b1, 400);
      leave();
   endtask : t_defaults
   task automatic t_timeout();
      enter(8'h7f);
      repeat (3) begin
         tick(900);
         chk(o_command_mode, 1'b1);
         put(8'h41);
      end
      wait_mode(1'b0, 2200);
      chk(16'(wcnt > 900), 1'b1);
   endtask : t_timeout
   task automatic t_abort();
      int n0;
      put(8'h41);
      repeat (3) put(8'h7f);
      tick(60);
      chk(o_command_mode, 1'b0);
      tick(50);
      n0 = nrx;
      put(8'h7f);
      put(8'h7f);
      put(8'h42);
      tick(2);
      chk(last_rx, 8'h42);
      chk(16'(nrx - n0), 1);
      tick(50);
      repeat (3) put(8'h7f);
      put(8'h43);
      tick(60);
      chk(o_command_mode, 1'b0);
      chk(last_rx, 8'h43);
   endtask : t_abort
   task automatic t_esc();
      i_escape_char_setting = 8'h1f;
      cfg();
      enter(8'h7f);
      leave();
      i_escape_char_setting = 8'h20;
      cfg();
      enter(8'h20);
      leave();
      put(8'h13);
      tick(2);
      chk(last_rx, 8'h13);
      chk(o_flow_output_pin, 1'b0);
      i_soft_flow_enable = 1'b1;
      cfg();
      put(8'h13);
      tick(2);
      chk(o_flow_output_pin, 1'b1);
      i_soft_flow_enable = 1'b0;
      cfg();
      chk(o_flow_output_pin, 1'b0);
   endtask : t_esc
   task automatic t_pins();
      logic p0, e;
      for (int c = 0; c < 4; c++) begin
         i_rx_indicator_config = c[1:0];
         cfg();
         i_rx_activity = 1'b0;
         tick(2);
         p0 = o_rx_indicator_pin;
         i_rx_activity = 1'b1;
         tick(2);
         if (c == 0) chk(p0 ^ o_rx_indicator_pin, 1'b1);
         else chk({p0, o_rx_indicator_pin}, c == 1 ? 2'h3 : 2'h0);
      end
      for (int f = 0; f < 6; f++) begin
         i_flow_config = f[2:0];
         cfg();
         for (int x = 0; x < 2; x++) begin
            {i_tx_active, i_host_room} = {2{x[0]}};
            tick(2);
            case (f)
               0, 1: e = ~x[0];
               2: e = 1'b1;
               3: e = x[0];
               default: e = 1'b0;
            endcase
            chk(o_flow_output_pin, e);
         end
      end
      i_flow_config = 3'h0;
      {i_tx_active, i_host_room} = 2'h1;
      cfg();
   endtask : t_pins
   task automatic t_chan();
      logic [4:0] ch [5] = '{5'h18, 5'h0c, 5'h19, 5'h06, 5'h07};
      logic [4:0] ek [5] = '{5'h18, 5'h0c, 5'h0c, 5'h06, 5'h06};
      for (int i = 0; i < 5; i++) begin
         i_single_freq_mode = (i < 3);
         i_channel_select = ch[i];
         cfg();
         chk(o_channel_select, ek[i]);
         if (i < 3) chk(o_freq_100khz, 14'h2391 + 14'(3 * ek[i]));
      end
   endtask : t_chan
   task automatic t_fwd();
      chk(o_dest_address, 16'h1234);
      pkt(16'h1234, 5'h06, 8'h40, 1'b0);
      i_rf_init_seen = 1'b1;
      tick(1);
      i_rf_init_seen = 1'b0;
      pkt(16'h1234, 5'h06, 8'h10, 1'b1);
      chk(o_signal_strength_query, 8'h25);
      pkt(16'h1235, 5'h06, 8'h50, 1'b0);
      pkt(16'h1234, 5'h05, 8'h50, 1'b0);
      pkt(16'h1234, 5'h06, 8'h80, 1'b1);
      chk(o_signal_strength_query, 8'h6a);
      pkt(16'h1234, 5'h06, 8'h40, 1'b1);
      chk(o_signal_strength_query, 8'h40);
   endtask : t_fwd
   task automatic t_init();
      txs(1'b0);
      i_force_initializer = 1'b1;
      tick(1);
      i_force_initializer = 1'b0;
      txs(1'b0);
      enter(8'h20);
      i_force_initializer = 1'b1;
      tick(1);
      i_force_initializer = 1'b0;
      leave();
      txs(1'b1);
      txs(1'b0);
      i_initializer_holdoff = 16'h0001;
      cfg();
      tick(2200);
      txs(1'b1);
      txs(1'b0);
   endtask : t_init
   //==========================================
   // main sequence
   initial begin
      {errors, samples_checked, nrx} = '0;
      {i_rst, i_exit_command, i_force_initializer, i_cfg_we} = 4'h8;
      {i_soft_flow_enable, i_single_freq_mode, i_rx_activity} = 3'h0;
      {i_tx_active, i_host_room, i_rf_pkt_valid} = 3'h2;
      {i_rf_init_seen, i_tx_start} = 2'h0;
      {i_guard_before_time, i_guard_after_time} = {16'h0003, 16'h0003};
      {i_command_timeout, i_initializer_holdoff} = {16'h0002, 16'hffff};
      {i_escape_char_setting, i_dest_address} = {8'h7f, 16'h1234};
      {i_rx_indicator_config, i_flow_config, i_channel_select} = '0;
      {i_rf_pkt_addr, i_rf_pkt_chan, i_rf_pkt_rssi} = '0;
      tick(6);
      chk(o_command_mode, 1'b0);
      chk(o_freq_100khz, 14'h2391);
      chk(o_signal_strength_query, 8'h25);
      i_rst = 1'b0;
      t_defaults();
      cfg();
      t_timeout();
      t_abort();
      t_esc();
      t_pins();
      t_chan();
      t_fwd();
      t_init();
      finish_test();
   end
endmodule : test_cmcfg_top
